// [dac_ctrl_map.vh]
// register offsets, field positions and reset values of the converter control block
`ifndef DAC_CTRL_MAP_VH
`define DAC_CTRL_MAP_VH

// register indices; byte address is four times the index
`define IDX_STATUS          8'h20
`define IDX_CONTROL_MAIN    8'h21
`define IDX_BUFFER_CONFIG   8'h22
`define IDX_BUFFER_POINTER  8'h23
`define ADDR_STATUS         12'h080
`define ADDR_CONTROL_MAIN   12'h084
`define ADDR_BUFFER_CONFIG  12'h088
`define ADDR_BUFFER_POINTER 12'h08c

// control main fields
`define BIT_CONVERTER_ENABLE    7
`define BIT_REFERENCE_SELECT    6
`define BIT_TRIGGER_SOURCE      5
`define BIT_SOFT_TRIGGER        4
`define BIT_LOW_POWER_SELECT    3
`define BIT_START_IRQ_ENABLE    1
`define BIT_LIMIT_IRQ_ENABLE    0
`define MASK_CONTROL_MAIN       8'heb

// buffer config fields
`define BIT_DMA_REQUEST_ENABLE  7
`define BIT_BUFFER_WORK_MODE    2
`define BIT_BUFFER_PTR_ENABLE   0
`define MASK_BUFFER_CONFIG      8'h85

// buffer pointer fields
`define BIT_READ_POINTER        4
`define BIT_UPPER_LIMIT         0
`define MASK_BUFFER_POINTER     8'h11

// status fields
`define BIT_START_FLAG          1
`define BIT_LIMIT_FLAG          0

// reset values
`define RST_CONTROL_MAIN        8'h00
`define RST_BUFFER_CONFIG       8'h00
`define RST_READ_POINTER        1'b0
`define RST_UPPER_LIMIT         1'b1
`define RST_STATUS              2'b10

`endif

// [trigger_edge_sync.v]
// two-flop synchroniser with rising-edge pulse for the hardware trigger
`timescale 1ns/1ns
`default_nettype none
module trigger_edge_sync (
   input  wire pclk,
   input  wire presetn,
   input  wire trigger_in,
   output wire trigger_pulse
);
   reg meta;
   reg sync;
   reg sync_last;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta      <= 1'b0;
         sync      <= 1'b0;
         sync_last <= 1'b0;
      end else begin
         meta      <= trigger_in;
         sync      <= meta;
         sync_last <= sync;
      end
   end

   assign trigger_pulse = sync & ~sync_last;
endmodule
`default_nettype wire

// [dac_buffer_control.v]
// APB register block and read-pointer control for the 12-bit converter
// Function
// - control bit 7 enables the converter system and starts the reference generator.
// - control bit 6 picks reference input one (0) or two (1).
// - control bit 5 picks hardware (0) or software (1) trigger source.
// - writing 1 to bit 4 advances pointer once if soft source and buffer enabled.
// - soft trigger bit is write-only, active high, reads back as zero.
// - control bit 3 selects high-power (0) or low-power (1) operation.
// - reserved bits of all three control registers read as zero.
// - control bit 1 enables the pointer-at-start interrupt.
// - control bit 0 enables the pointer-at-limit interrupt.
// - config bit 7 turns flag events into DMA requests instead of interrupts.
// - with DMA enabled no interrupt request is presented for those events.
// - config bit 2 selects normal (0) or one-time scan (1) buffer mode.
// - config bit 0 off: word zero converted; on: pointer selects word.
// - pointer register shows the current read pointer at any time.
// - pointer register bit 0 is the upper limit; pointer never exceeds it.
// - normal mode: trigger at the limit wraps the pointer to zero.
// - one-time scan: pointer advances to the limit and holds there.
// - limit flag set when pointer equals limit, start flag when pointer is zero.
// - DMA done drops the request and clears the related status flags.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "dac_ctrl_map.vh"
module dac_buffer_control (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        hw_trigger,
   input  wire        dma_done,
   output wire        dma_request,
   output wire        irq_request,
   output reg         converter_enable,
   output reg         reference_select,
   output reg         low_power_select,
   output reg         buffer_word_select
);
   reg        trigger_source_select;
   reg        start_flag_irq_enable;
   reg        limit_flag_irq_enable;
   reg        dma_request_enable;
   reg        buffer_work_mode;
   reg        buffer_pointer_enable;
   reg        buffer_read_pointer;
   reg        buffer_upper_limit;
   reg        pointer_at_start_flag;
   reg        pointer_at_limit_flag;
   reg        dma_pending;
   reg        next_pointer;
   reg        was_at_start;
   reg        was_at_limit;

   wire       hw_pulse;
   wire       access;
   wire       wr;
   wire       sel_status;
   wire       sel_main;
   wire       sel_config;
   wire       sel_pointer;
   wire       mapped;
   wire       soft_fire;
   wire       advance;
   wire       status_clear_start;
   wire       status_clear_limit;
   wire       at_start;
   wire       at_limit;
   wire       start_event;
   wire       limit_event;
   wire       flag_pending;

   // address match against a byte address
   function hit;
      input [11:0] addr;
      input [11:0] target;
      begin
         hit = (addr == target);
      end
   endfunction

   trigger_edge_sync u_trig (
      .pclk          (pclk),
      .presetn       (presetn),
      .trigger_in    (hw_trigger),
      .trigger_pulse (hw_pulse)
   );

   // zero-wait slave; every transfer ends in its first access cycle
   assign pready      = 1'b1;
   assign access      = psel & penable;
   assign wr          = access & pwrite;
   assign sel_status  = hit(paddr, `ADDR_STATUS);
   assign sel_main    = hit(paddr, `ADDR_CONTROL_MAIN);
   assign sel_config  = hit(paddr, `ADDR_BUFFER_CONFIG);
   assign sel_pointer = hit(paddr, `ADDR_BUFFER_POINTER);
   assign mapped      = sel_status | sel_main | sel_config | sel_pointer;
   assign pslverr     = access & ~mapped;

   assign soft_fire = wr & sel_main & pwdata[`BIT_SOFT_TRIGGER]
                    & trigger_source_select & buffer_pointer_enable;

   assign advance = buffer_pointer_enable &
                    (trigger_source_select ? soft_fire : hw_pulse);

   // status is write-zero-to-clear
   assign status_clear_start = wr & sel_status & ~pwdata[`BIT_START_FLAG];
   assign status_clear_limit = wr & sel_status & ~pwdata[`BIT_LIMIT_FLAG];

   assign at_start = (buffer_read_pointer == 1'b0);
   assign at_limit = (buffer_read_pointer == buffer_upper_limit);
   // flags only set when buffer state changes into the position
   assign start_event = at_start & ~was_at_start;
   assign limit_event = at_limit & ~was_at_limit;

   always @* begin
      next_pointer = buffer_read_pointer;
      if (advance) begin
         if (at_limit) begin
            if (buffer_work_mode) begin
               next_pointer = buffer_read_pointer;
            end else begin
               next_pointer = 1'b0;
            end
         end else begin
            next_pointer = ~buffer_read_pointer;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         converter_enable      <= 1'b0;
         reference_select      <= 1'b0;
         trigger_source_select <= 1'b0;
         low_power_select      <= 1'b0;
         start_flag_irq_enable <= 1'b0;
         limit_flag_irq_enable <= 1'b0;
         dma_request_enable    <= 1'b0;
         buffer_work_mode      <= 1'b0;
         buffer_pointer_enable <= 1'b0;
         buffer_upper_limit    <= `RST_UPPER_LIMIT;
         buffer_read_pointer   <= `RST_READ_POINTER;
      end else begin
         if (wr & sel_main) begin
            converter_enable      <= pwdata[`BIT_CONVERTER_ENABLE];
            reference_select      <= pwdata[`BIT_REFERENCE_SELECT];
            trigger_source_select <= pwdata[`BIT_TRIGGER_SOURCE];
            low_power_select      <= pwdata[`BIT_LOW_POWER_SELECT];
            start_flag_irq_enable <= pwdata[`BIT_START_IRQ_ENABLE];
            limit_flag_irq_enable <= pwdata[`BIT_LIMIT_IRQ_ENABLE];
         end
         if (wr & sel_config) begin
            dma_request_enable    <= pwdata[`BIT_DMA_REQUEST_ENABLE];
            buffer_work_mode      <= pwdata[`BIT_BUFFER_WORK_MODE];
            buffer_pointer_enable <= pwdata[`BIT_BUFFER_PTR_ENABLE];
         end
         if (wr & sel_pointer) begin
            // clamp to limit; a written pointer above the limit is held at it
            buffer_upper_limit  <= pwdata[`BIT_UPPER_LIMIT];
            buffer_read_pointer <= pwdata[`BIT_READ_POINTER] & pwdata[`BIT_UPPER_LIMIT];
         end else if (buffer_read_pointer > buffer_upper_limit) begin
            buffer_read_pointer <= buffer_upper_limit;
         end else begin
            buffer_read_pointer <= next_pointer;
         end
      end
   end

   // sticky flags; a set in the clearing cycle wins
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // start flag is set out of reset, pointer sits at zero
         pointer_at_start_flag <= 1'b1;
         pointer_at_limit_flag <= 1'b0;
         was_at_start          <= 1'b1;
         was_at_limit          <= 1'b1;
         dma_pending           <= 1'b0;
      end else begin
         was_at_start <= at_start;
         was_at_limit <= at_limit;
         if (start_event) begin
            pointer_at_start_flag <= 1'b1;
         end else if (status_clear_start | (dma_pending & dma_done)) begin
            pointer_at_start_flag <= 1'b0;
         end
         if (limit_event) begin
            pointer_at_limit_flag <= 1'b1;
         end else if (status_clear_limit | (dma_pending & dma_done)) begin
            pointer_at_limit_flag <= 1'b0;
         end
         if (dma_pending & dma_done) begin
            dma_pending <= 1'b0;
         end else if (dma_request_enable & flag_pending) begin
            dma_pending <= 1'b1;
         end else if (!dma_request_enable) begin
            dma_pending <= 1'b0;
         end
      end
   end

   assign flag_pending = (pointer_at_start_flag & start_flag_irq_enable)
                       | (pointer_at_limit_flag & limit_flag_irq_enable);

   assign dma_request = dma_pending;
   assign irq_request = flag_pending & ~dma_request_enable;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buffer_word_select <= 1'b0;
      end else begin
         buffer_word_select <= buffer_pointer_enable & buffer_read_pointer;
      end
   end

   // read mux, reserved and soft trigger read zero
   always @* begin
      prdata = 32'h00000000;
      if (access & ~pwrite) begin
         if (sel_status) begin
            prdata[`BIT_START_FLAG] = pointer_at_start_flag;
            prdata[`BIT_LIMIT_FLAG] = pointer_at_limit_flag;
         end else if (sel_main) begin
            prdata[`BIT_CONVERTER_ENABLE] = converter_enable;
            prdata[`BIT_REFERENCE_SELECT] = reference_select;
            prdata[`BIT_TRIGGER_SOURCE]   = trigger_source_select;
            prdata[`BIT_LOW_POWER_SELECT] = low_power_select;
            prdata[`BIT_START_IRQ_ENABLE] = start_flag_irq_enable;
            prdata[`BIT_LIMIT_IRQ_ENABLE] = limit_flag_irq_enable;
         end else if (sel_config) begin
            prdata[`BIT_DMA_REQUEST_ENABLE] = dma_request_enable;
            prdata[`BIT_BUFFER_WORK_MODE]   = buffer_work_mode;
            prdata[`BIT_BUFFER_PTR_ENABLE]  = buffer_pointer_enable;
         end else if (sel_pointer) begin
            prdata[`BIT_READ_POINTER] = buffer_read_pointer;
            prdata[`BIT_UPPER_LIMIT]  = buffer_upper_limit;
         end
      end
   end
endmodule
`default_nettype wire

// [dac_far_side_model.sv]
// trigger source and dma controller standing beyond the converter block
`timescale 1ns/1ns
`default_nettype none
module dac_far_side_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       fire,
   input  wire logic [3:0] lag,
   input  wire logic       dma_request,
   output logic            hw_trigger,
   output logic            dma_done
);
   logic [3:0] n;
   logic [1:0] t;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         n <= 4'h0;
         t <= 2'h0;
         dma_done <= 1'b0;
      end else begin
         dma_done <= 1'b0;
         n <= 4'h0;
         if (dma_request && !dma_done) begin
            n <= n + 4'h1;
            if (n == lag) dma_done <= 1'b1;
         end
         // a trigger held three cycles, long enough for the synchroniser
         if (fire) t <= 2'h3;
         else if (t != 2'h0) t <= t - 2'h1;
      end
   end
   assign hw_trigger = t != 2'h0;
endmodule
`default_nettype wire

// [dac_buffer_control_properties.sv]
// concurrent checks on the converter control block ports
`timescale 1ns/1ns
`default_nettype none
`include "dac_ctrl_map.vh"
module dac_buffer_control_properties (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        dma_done,
   input wire logic        dma_request,
   input wire logic        irq_request,
   input wire logic        converter_enable,
   input wire logic        reference_select,
   input wire logic        low_power_select,
   input wire logic        buffer_word_select
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic       acc = psel && penable;
   wire logic       rd = acc && !pwrite;
   wire logic       wm = acc && pwrite && paddr == `ADDR_CONTROL_MAIN;
   wire logic       wc = acc && pwrite && paddr == `ADDR_BUFFER_CONFIG;
   // bit 4 of the main register is left out of keep, so it is checked here as well as by its own check
   wire logic [7:0] keep = paddr == `ADDR_CONTROL_MAIN ? 8'heb :
                           paddr == `ADDR_BUFFER_CONFIG ? 8'h85 :
                           paddr == `ADDR_BUFFER_POINTER ? 8'h11 : 8'hff;
   chk_enable_follows: assert property (wm |=> converter_enable == $past(pwdata[7]))
      else $error("converter enable wrong after write");
   chk_reference_follows: assert property (wm |=> reference_select == $past(pwdata[6]))
      else $error("reference select wrong after write");
   chk_power_follows: assert property (wm ##1 1'b1 |-> low_power_select == $past(pwdata[3]))
      else $error("low power select wrong after write");
   chk_trigger_reads_zero: assert property (rd && paddr == `ADDR_CONTROL_MAIN |-> !prdata[4])
      else $error("soft trigger bit read back as one");
   chk_reserved_zero: assert property (rd |-> (prdata & ~{24'h0, keep}) == 32'h0)
      else $error("reserved bits read as nonzero");
   chk_no_irq_dma: assert property (!(dma_request && irq_request))
      else $error("interrupt and dma request at once");
   chk_done_drops_req: assert property (dma_request && dma_done |=> !dma_request)
      else $error("dma request stayed after done");
   chk_word_zero_off: assert property (wc && !pwdata[0] |-> ##2 !buffer_word_select)
      else $error("word select nonzero with buffer off");
endmodule
`default_nettype wire

// [dac_buffer_control_tb.sv]
// self-checking bench for the converter buffer control block
`timescale 1ns/1ns
`default_nettype none
`include "dac_ctrl_map.vh"
module dac_buffer_control_tb;
   localparam logic [11:0] cm = `ADDR_CONTROL_MAIN;
   localparam logic [11:0] cf = `ADDR_BUFFER_CONFIG;
   localparam logic [11:0] pt = `ADDR_BUFFER_POINTER;
   localparam logic [11:0] st = `ADDR_STATUS;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic        pready, pslverr, dma_done, dma_request, irq_request, err;
   logic        converter_enable, reference_select, low_power_select;
   logic        buffer_word_select, hw_trigger, fire = 1'b0;
   logic [3:0]  lag = 4'h0;
   int          n_mismatch = 0, checked = 0, cyc = 0, n;
   dac_buffer_control u_dac_buffer_control (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .hw_trigger, .dma_done, .dma_request, .irq_request,
      .converter_enable, .reference_select, .low_power_select, .buffer_word_select);
   dac_far_side_model u_dac_far_side_model (.pclk, .presetn, .fire, .lag, .dma_request,
      .hw_trigger, .dma_done);
   initial begin
      forever #50 pclk = ~pclk;
   end
   task automatic final_report;
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // a hang is cut short well beyond the few hundred cycles the tests need
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_mismatch++;
         final_report;
      end
   end
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask
   task automatic rdc(input string s, input logic [11:0] a, input logic [31:0] e);
      apb(a, 1'b0, 32'h0);
      chk(s, e, r);
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rdc("main", cm, 32'h00);
      rdc("config", cf, 32'h00);
      rdc("pointer", pt, 32'h01);
      rdc("status", st, 32'h02);
      $display("test reset done");
      wr(cm, 32'hffffffff);
      rdc("main", cm, 32'heb);
      rdc("pointer", pt, 32'h01);
      @(negedge pclk);
      chk("enable", 32'h1, converter_enable);
      chk("low power", 32'h1, low_power_select);
      wr(cm, 32'h40);
      @(negedge pclk);
      chk("enable", 32'h0, converter_enable);
      chk("reference", 32'h1, reference_select);
      chk("low power", 32'h0, low_power_select);
      wr(cf, 32'hfe);
      rdc("config", cf, 32'h84);
      wr(pt, 32'hff);
      rdc("pointer", pt, 32'h11);
      $display("test registers done");
      wr(cf, 32'h01);
      wr(cm, 32'h23);
      wr(pt, 32'h01);
      wr(st, 32'h00);
      wr(cm, 32'h33);
      rdc("pointer", pt, 32'h11);
      chk("word", 32'h1, buffer_word_select);
      rdc("status", st, 32'h01);
      wr(cm, 32'h33);
      rdc("pointer", pt, 32'h01);
      rdc("status", st, 32'h03);
      chk("irq both", 32'h1, irq_request);
      wr(st, 32'h02);
      wr(cm, 32'h21);
      @(negedge pclk);
      chk("irq limit", 32'h0, irq_request);
      wr(cm, 32'h22);
      @(negedge pclk);
      chk("irq start", 32'h1, irq_request);
      $display("test normal done");
      wr(cf, 32'h05);
      wr(pt, 32'h01);
      for (int k = 0; k < 2; k++) begin
         wr(cm, 32'h32);
         rdc("scan", pt, 32'h11);
      end
      wr(pt, 32'h10);
      rdc("clamp", pt, 32'h00);
      wr(cm, 32'h32);
      rdc("limit zero", pt, 32'h00);
      $display("test scan done");
      for (int k = 0; k < 2; k++) begin
         lag <= 4'(k * 6);
         wr(cf, 32'h01);
         wr(pt, 32'h01);
         wr(st, 32'h00);
         wr(cf, 32'h81);
         wr(cm, 32'h33);
         @(negedge pclk);
         chk("dma irq", 32'h0, irq_request);
         n = 0;
         do begin
            apb(st, 1'b0, 32'h0);
            n++;
         end while (r !== 32'h0 && n < 20);
         chk("dma status", 32'h0, r);
         chk("dma req", 32'h0, dma_request);
      end
      wr(cf, 32'h01);
      wr(pt, 32'h01);
      $display("test dma done");
      wr(cm, 32'h00);
      for (int k = 0; k < 2; k++) begin
         wr(cm, k ? 32'h20 : 32'h10);
         rdc("hw pre", pt, k ? 32'h11 : 32'h01);
         @(posedge pclk);
         fire <= 1'b1;
         @(posedge pclk);
         fire <= 1'b0;
         repeat (6) @(posedge pclk);
         rdc("hw post", pt, 32'h11);
      end
      apb(12'h0f0, 1'b0, 32'h0);
      chk("unmapped data", 32'h0, r);
      chk("unmapped err", 32'h1, err);
      $display("test trigger done");
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc("pointer", pt, 32'h01);
      $display("test second reset done");
      final_report;
   end
endmodule
bind dac_buffer_control dac_buffer_control_properties u_dac_buffer_control_properties (.pclk,
   .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .dma_done, .dma_request,
   .irq_request, .converter_enable, .reference_select, .low_power_select, .buffer_word_select);
`default_nettype wire
